/* File: hdl/asq_pkg.sv */
/*
  constants, bus carriers and state layout for the converter sequencer.
  assumes one 125 MHz clock, an AXI4-Lite master and an analog front end outside.
*/
// What this block does
// - converter runs only while the enable bit is one; off draws no current.
// - writing go while enable is already one starts a conversion; go reads one while it runs.
// - on completion go clears, done flag sets, result loads.
// - clearing go mid-conversion stops it; result keeps the old value.
// - after an abort wait two bit periods, then acquire the selected channel.
// - reset returns every register to reset value, module off, conversion ended.
// - conversion in low power works only with the dedicated RC clock.
// - with the RC clock, start is delayed one instruction cycle.
// - low power completion wakes if irq enabled, else module powers down.
// - other clocks: entering low power aborts and powers down, enable stays.
// - external trigger sets go and clears the sixteen bit timer.
// - channel field bits 5..3: codes 000..011 inputs, 100 up reserved.
// - clock field 00,01,10,11: fosc/2, fosc/8, fosc/32, RC oscillator.
// - a full conversion takes nine and a half bit periods.
// - done flag sets on every completion; only software clears it.
package asq_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] RESULT_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS = 8'h0C;
  localparam int EN_BIT = 0;
  localparam int GO_BIT = 2;
  localparam int CHS_LSB = 3;
  localparam int CKS_LSB = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] CKS_RC = 2'h3;
  localparam logic [2:0] CHS_LAST = 3'h3;
  localparam int CLK_NS = 8;
  localparam int RC_TAD_NS = 4000;
  localparam int RC_HALF = RC_TAD_NS / CLK_NS / 2;
  localparam int INSTR_CLKS = 4;
  localparam logic [4:0] HALF_LAST = 5'h12;
  localparam logic [4:0] ABORT_LAST = 5'h03;
  localparam logic [8:0] HALF_MIN = 9'h003;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_DLY = 4'b0010,
    S_CONV = 4'b0100,
    S_ABORT = 4'b1000
  } asq_state_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } asq_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } asq_axil_rsp_t;

  typedef struct packed {
    logic power_on;
    logic sample_en;
    logic convert_act;
    logic [2:0] channel;
    logic [7:0] dac_code;
  } asq_afe_t;

  typedef struct packed {
    asq_axil_rsp_t rsp;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic wlane;
    logic enable;
    logic [2:0] chan;
    logic [1:0] cks;
    logic [7:0] result;
    logic [7:0] sar;
    logic done_st;
    logic irq_en;
    logic irq;
    logic wake;
    logic timer_clr;
    logic pdown;
    asq_state_t fsm;
    logic [4:0] hc;
    logic [8:0] div;
    logic [2:0] dly;
    logic cs1;
    logic cs2;
    asq_afe_t afe;
  } asq_st_t;

  localparam asq_st_t ST_RST = '{fsm: S_IDLE, default: '0};
endpackage : asq_pkg

/* File: hdl/asq_sequencer.sv */
/*
  converter sequencer: AXI4-Lite register slave, bit period divider, successive
  approximation control, abort, low power and trigger handling.
  assumes comparator input is asynchronous; trigger and low power request are on aclk.
*/
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module asq_sequencer #(
  parameter int RC_HALF_CLKS = asq_pkg::RC_HALF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire asq_pkg::asq_axil_req_t axi_req,
  output asq_pkg::asq_axil_rsp_t axi_rsp,
  input wire logic comp_in,
  input wire logic low_power_req,
  input wire logic special_trigger,
  output asq_pkg::asq_afe_t afe,
  output logic timer_clear,
  output logic wake_req,
  output logic irq
);
  import asq_pkg::*;

  asq_st_t st_reg;
  asq_st_t st_next;

  logic [8:0] half_raw;
  logic [8:0] half_lim;
  logic half_tick;
  logic busy;
  logic start;
  logic abort;
  logic wr_fire;
  logic [2:0] bit_idx;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_ofs;

  // half bit period in clocks; counting halves gives the 9.5 period length exactly
  always_comb
  begin
    case (st_reg.cks)
      2'h0: half_raw = 9'h001;
      2'h1: half_raw = 9'h004;
      2'h2: half_raw = 9'h010;
      default: half_raw = RC_HALF_CLKS[8:0];
    endcase
    // the comparator answer needs three clocks through its synchroniser;
    // shorter halves are stretched, so fosc/2 runs slower than nominal
    half_lim = (half_raw < HALF_MIN) ? HALF_MIN : half_raw;
  end

  assign half_tick = (st_reg.div == 9'(half_lim - 9'h001));
  assign busy = (st_reg.fsm == S_DLY) || (st_reg.fsm == S_CONV);
  assign bit_idx = 3'(3'h7 - st_reg.hc[3:1]);
  assign wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.rsp.bvalid;
  assign ctrl_rd = {st_reg.cks, st_reg.chan, busy, 1'b0, st_reg.enable};
  assign rd_ofs = axi_req.araddr[7:0];

  always_comb
  begin
    st_next = st_reg;
    st_next.timer_clr = 1'b0;
    st_next.wake = 1'b0;
    start = 1'b0;
    abort = 1'b0;
    // comparator crosses in from the analog side
    st_next.cs1 = comp_in;
    st_next.cs2 = st_reg.cs1;

    // write address and data are taken in either order
    if (axi_req.awvalid && st_reg.rsp.awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.waddr = (axi_req.awaddr[31:8] == 24'h000000) ? axi_req.awaddr[7:0] : 8'hFF;
    end
    if (axi_req.wvalid && st_reg.rsp.wready)
    begin
      st_next.w_got = 1'b1;
      st_next.wdata = axi_req.wdata[7:0];
      st_next.wlane = axi_req.wstrb[0];
    end
    if (st_reg.rsp.bvalid && axi_req.bready)
      st_next.rsp.bvalid = 1'b0;
    if (wr_fire)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.rsp.bvalid = 1'b1;
      st_next.rsp.bresp = RESP_OK;
      case (st_reg.waddr)
        CTRL_OFS:
        begin
          if (st_reg.wlane)
          begin
            st_next.enable = st_reg.wdata[EN_BIT];
            st_next.chan = st_reg.wdata[CHS_LSB +: 3];
            st_next.cks = st_reg.wdata[CKS_LSB +: 2];
            // go only counts when the enable was already on before this write
            if (st_reg.wdata[GO_BIT] && st_reg.enable && st_reg.fsm == S_IDLE)
              start = 1'b1;
            if (!st_reg.wdata[GO_BIT] && busy)
              abort = 1'b1;
          end
        end
        STAT_OFS:
        begin
          if (st_reg.wlane && st_reg.wdata[0])
            st_next.done_st = 1'b0;
        end
        MASK_OFS:
        begin
          if (st_reg.wlane)
            st_next.irq_en = st_reg.wdata[0];
        end
        RESULT_OFS: ;
        default: st_next.rsp.bresp = RESP_ERR;
      endcase
    end
    st_next.rsp.awready = !st_next.aw_got && !st_next.rsp.bvalid;
    st_next.rsp.wready = !st_next.w_got && !st_next.rsp.bvalid;

    // reads answer one clock after the address is taken
    if (st_reg.rsp.rvalid && axi_req.rready)
      st_next.rsp.rvalid = 1'b0;
    if (axi_req.arvalid && st_reg.rsp.arready)
    begin
      st_next.rsp.rvalid = 1'b1;
      st_next.rsp.rresp = RESP_OK;
      st_next.rsp.rdata = 32'h00000000;
      if (axi_req.araddr[31:8] != 24'h000000)
        st_next.rsp.rresp = RESP_ERR;
      else
      begin
        case (rd_ofs)
          CTRL_OFS: st_next.rsp.rdata[7:0] = ctrl_rd;
          RESULT_OFS: st_next.rsp.rdata[7:0] = st_reg.result;
          STAT_OFS: st_next.rsp.rdata[0] = st_reg.done_st;
          MASK_OFS: st_next.rsp.rdata[0] = st_reg.irq_en;
          default: st_next.rsp.rresp = RESP_ERR;
        endcase
      end
    end
    st_next.rsp.arready = !st_next.rsp.rvalid;

    // hardware trigger starts even with a software write in the same cycle, unless that write clears enable
    if (special_trigger && st_reg.enable && st_reg.fsm == S_IDLE)
    begin
      start = 1'b1;
      st_next.timer_clr = 1'b1;
    end

    if (st_reg.fsm == S_IDLE || st_reg.fsm == S_DLY)
      st_next.div = 9'h000;
    else
      st_next.div = half_tick ? 9'h000 : 9'(st_reg.div + 9'h001);

    case (st_reg.fsm)
      S_IDLE:
      begin
        if (start)
        begin
          st_next.sar = 8'h00;
          st_next.hc = 5'h00;
          st_next.dly = 3'h0;
          st_next.pdown = 1'b0;
          // the clock chosen in the starting write already counts
          st_next.fsm = (st_next.cks == CKS_RC) ? S_DLY : S_CONV;
        end
      end
      S_DLY:
      begin
        if (abort)
        begin
          st_next.hc = 5'h00;
          st_next.fsm = S_ABORT;
        end
        else if (st_reg.dly == 3'(INSTR_CLKS - 1))
          st_next.fsm = S_CONV;
        else
          st_next.dly = 3'(st_reg.dly + 3'h1);
      end
      S_CONV:
      begin
        if (abort)
        begin
          st_next.hc = 5'h00;
          st_next.fsm = S_ABORT;
        end
        else if (half_tick)
        begin
          if (st_reg.hc < 5'h10)
          begin
            if (!st_reg.hc[0])
              st_next.sar[bit_idx] = 1'b1;
            else if (!st_reg.cs2)
              st_next.sar[bit_idx] = 1'b0;
          end
          if (st_reg.hc == HALF_LAST)
          begin
            st_next.result = st_reg.sar;
            st_next.done_st = 1'b1;
            st_next.fsm = S_IDLE;
            if (low_power_req && st_reg.irq_en)
              st_next.wake = 1'b1;
            if (low_power_req && !st_reg.irq_en)
              st_next.pdown = 1'b1;
          end
          else
            st_next.hc = 5'(st_reg.hc + 5'h01);
        end
      end
      S_ABORT:
      begin
        // two bit periods of rest, then acquisition restarts by itself
        if (half_tick)
        begin
          if (st_reg.hc == ABORT_LAST)
            st_next.fsm = S_IDLE;
          else
            st_next.hc = 5'(st_reg.hc + 5'h01);
        end
      end
      default: st_next.fsm = S_IDLE;
    endcase

    // only the RC clock keeps running while the core sleeps
    if (low_power_req && st_reg.cks != CKS_RC)
    begin
      st_next.fsm = S_IDLE;
      st_next.pdown = 1'b1;
    end
    if (!low_power_req && st_reg.pdown && !start)
      st_next.pdown = 1'b0;
    if (!st_next.enable)
      st_next.fsm = S_IDLE;

    st_next.irq = st_next.done_st && st_next.irq_en;
    st_next.afe.power_on = st_next.enable && !st_next.pdown;
    // reserved channel codes never connect an input to the sampler
    st_next.afe.sample_en = st_next.afe.power_on && st_next.fsm == S_IDLE
      && st_next.chan <= CHS_LAST;
    st_next.afe.convert_act = st_next.fsm == S_CONV;
    st_next.afe.channel = st_next.chan;
    st_next.afe.dac_code = st_next.sar;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  assign axi_rsp = st_reg.rsp;
  assign afe = st_reg.afe;
  assign timer_clear = st_reg.timer_clr;
  assign wake_req = st_reg.wake;
  assign irq = st_reg.irq;
endmodule : asq_sequencer

/* File: tb/asq_properties.sv */
/* checker: timing relations at the sequencer ports.
   assumes it is bound to the sequencer and one clock domain. */
`timescale 1ns/100ps
module asq_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire asq_pkg::asq_axil_req_t axi_req,
  input wire asq_pkg::asq_axil_rsp_t axi_rsp,
  input wire logic comp_in,
  input wire logic low_power_req,
  input wire logic special_trigger,
  input wire asq_pkg::asq_afe_t afe,
  input wire logic timer_clear,
  input wire logic wake_req,
  input wire logic irq
);
  import asq_pkg::*;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  localparam int FIRST_MAX = 300;
  sequence wr_taken;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence sar_first;
    afe.dac_code == 8'h00 ##[1:FIRST_MAX] afe.dac_code == 8'h80;
  endsequence
  wr_answer_a:
    assert property (wr_taken |-> ##2 axi_rsp.bvalid) else $error("write answer late");
  rd_answer_a:
    assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("read answer late");
  b_release_a:
    assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid) else $error("write answer held");
  trig_clear_a:
    assert property (timer_clear |-> $past(special_trigger) ##1 !timer_clear) else $error("bad timer clear");
  wake_pulse_a:
    assert property (wake_req |-> $past(low_power_req) ##1 !wake_req) else $error("bad wake pulse");
  off_quiet_a:
    assert property (!afe.power_on |-> !afe.convert_act && !afe.sample_en) else $error("active while off");
  sample_conv_a:
    assert property (!(afe.sample_en && afe.convert_act)) else $error("sample during conversion");
  reset_clear_a:
    assert property ($rose(aresetn) |-> afe == '0 && !irq && !wake_req) else $error("reset left state");
  sar_start_a:
    assert property ($rose(afe.convert_act) |-> sar_first) else $error("first trial not msb");
endmodule : asq_properties
bind asq_sequencer asq_properties u_asq_properties (.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .comp_in(comp_in), .low_power_req(low_power_req), .special_trigger(special_trigger),
  .afe(afe), .timer_clear(timer_clear), .wake_req(wake_req), .irq(irq));

/* File: tb/asq_afe_model.sv */
/* front end model: comparator against a held level vin.
   assumes trial codes come from the sequencer. */
`timescale 1ns/100ps
module asq_afe_model (
  input wire logic aclk,
  input wire asq_pkg::asq_afe_t afe,
  input wire logic [7:0] vin,
  output logic comp_in
);
  import asq_pkg::*;
  logic tog = 1'b0;
  // outside a conversion the answer means nothing, so it keeps moving
  always @(posedge aclk) tog <= !tog;
  assign comp_in = afe.convert_act ? (vin >= afe.dac_code) : tog;
endmodule : asq_afe_model

/* File: tb/adc_conversion_sequencer_tb_top.sv */
/* bench: bus tasks and conversion scenarios for the sequencer.
   assumes a short RC half period of 4 clocks in this run. */
`timescale 1ns/100ps
module adc_conversion_sequencer_tb_top;
  import asq_pkg::*;
  localparam int RC_SIM = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic lp = 1'b0;
  logic trg = 1'b0;
  logic comp_in, tclr, wake, irq;
  logic [7:0] vin = 8'h00;
  logic [31:0] d;
  logic [1:0] rs;
  int n_errors = 0;
  int samples_checked = 0;
  int n_act = 0;
  int c;
  asq_axil_req_t q = '{wstrb: 4'hF, default: '0};
  asq_axil_rsp_t r;
  asq_afe_t afe;
  wire [4:0] ev = {tclr, afe.power_on, irq, wake, afe.sample_en};
  asq_sequencer #(.RC_HALF_CLKS(RC_SIM)) u_asq_sequencer (.aclk(aclk), .aresetn(aresetn), .axi_req(q),
    .axi_rsp(r), .comp_in(comp_in), .low_power_req(lp), .special_trigger(trg), .afe(afe),
    .timer_clear(tclr), .wake_req(wake), .irq(irq));
  asq_afe_model u_asq_afe_model (.aclk(aclk), .afe(afe), .vin(vin), .comp_in(comp_in));
  initial forever #4 aclk = ~aclk;
  always @(posedge aclk) if (afe.convert_act === 1'b1) n_act <= n_act + 1;
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    n_errors += (s !== e);
    if (s !== e) $display("unexpected at %0t: got %h want %h", $time, s, e);
  endtask : chk
  task stop;
    n_errors++;
    $display("unexpected at %0t: wait ran out", $time);
    end_sim;
  endtask : stop
  // every ready and answer is taken at the rising edge that completes its handshake
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    int k;
    @(posedge aclk);
    q.awvalid <= w;
    q.wvalid <= w;
    q.bready <= w;
    q.arvalid <= !w;
    q.rready <= !w;
    q.awaddr <= 32'(a);
    q.araddr <= 32'(a);
    q.wdata <= 32'(v);
    for (k = 0; k < 99; k++)
    begin
      @(posedge aclk);
      if (q.awvalid && r.awready) q.awvalid <= 1'b0;
      if (q.wvalid && r.wready) q.wvalid <= 1'b0;
      if (q.arvalid && r.arready) q.arvalid <= 1'b0;
      d = r.rdata;
      rs = w ? r.bresp : r.rresp;
      if (w ? r.bvalid : r.rvalid) break;
    end
    q.bready <= 1'b0;
    q.rready <= 1'b0;
    if (k == 99) stop;
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
    chk(rs, RESP_OK);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(d, e);
  endtask : rd
  task wt(input int s, input logic v);
    int k;
    for (k = 0; k < 2000 && ev[s] !== v; k++) @(negedge aclk);
    if (k == 2000) stop;
  endtask : wt
  task idle;
    int k;
    k = 0;
    do bus(1'b0, CTRL_OFS, 8'h00); while (d[GO_BIT] !== 1'b0 && ++k < 500);
    if (k == 500) stop;
  endtask : idle
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (c = 0; c < 4; c++) rd(8'(c * 4), 8'h00);
    bus(1'b1, 8'h10, 8'h00);
    chk(rs, RESP_ERR);
    wr(CTRL_OFS, 8'h05);
    rd(CTRL_OFS, 8'h01);
    for (c = 0; c < 4; c++)
    begin
      vin <= 8'(8'h3C + c * 40);
      wr(CTRL_OFS, {2'(c), 6'h09});
      n_act = 0;
      wr(CTRL_OFS, {2'(c), 6'h0D});
      rd(CTRL_OFS, {2'(c), 6'h0D});
      idle();
      rd(RESULT_OFS, vin);
      chk(n_act, 19 * (c == 0 ? int'(HALF_MIN) : c == 3 ? RC_SIM : 4 ** c));
      rd(STAT_OFS, 8'h01);
      wr(STAT_OFS, 8'h01);
    end
    wr(MASK_OFS, 8'h01);
    wr(CTRL_OFS, 8'h0D);
    wt(2, 1'b1);
    wr(STAT_OFS, 8'h01);
    chk(irq, 1'b0);
    wr(MASK_OFS, 8'h00);
    c = vin;
    vin <= 8'hC3;
    wr(CTRL_OFS, 8'h0D);
    wr(CTRL_OFS, 8'h09);
    chk(afe.sample_en, 1'b0);
    wt(0, 1'b1);
    rd(RESULT_OFS, 8'(c));
    rd(STAT_OFS, 8'h00);
    trg <= 1'b1;
    @(posedge aclk);
    trg <= 1'b0;
    wt(4, 1'b1);
    rd(CTRL_OFS, 8'h0D);
    idle();
    rd(RESULT_OFS, 8'hC3);
    wr(STAT_OFS, 8'h01);
    wr(CTRL_OFS, 8'h0D);
    lp <= 1'b1;
    wt(3, 1'b0);
    rd(CTRL_OFS, 8'h09);
    lp <= 1'b0;
    for (c = 1; c >= 0; c--)
    begin
      wr(MASK_OFS, 8'(c));
      wr(CTRL_OFS, 8'hCD);
      lp <= 1'b1;
      wt(c ? 1 : 3, c[0]);
      chk(afe.power_on, c[0]);
      rd(CTRL_OFS, 8'hC9);
      lp <= 1'b0;
      wr(STAT_OFS, 8'h01);
    end
    wr(CTRL_OFS, 8'h29);
    rd(CTRL_OFS, 8'h29);
    chk(afe.sample_en, 1'b0);
    chk(afe.channel, 3'h5);
    wr(CTRL_OFS, 8'h00);
    chk(afe.power_on, 1'b0);
    end_sim;
  end
endmodule : adc_conversion_sequencer_tb_top
